// >>> logic/ccd_clock_ctrl.sv
/*
  Clock source control: oscillator enables, crystal settle counter,
  missing-clock detection with fallback, software return, dual-speed
  start-up and a break-before-make system clock gate pair.
  Assumes the external oscillator is seen as a one-cycle pulse per
  oscillator cycle, already synchronous to i_clk, and that the
  glitch-free clock mux downstream obeys the two gate enables.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defs.svh"

////////////////////////////////////////////////////////////////////////
module ccd_clock_ctrl
  import ccd_pkg::*;
#(
  parameter int SETTLE_COUNT = `CCD_SETTLE_CYCLES,
  parameter int MISS_CYCLES =
    (`CCD_MISS_TIME_NS * 1000) / `CCD_CLK_PERIOD_PS,
  parameter int GAP_CYCLES =
    (`CCD_GAP_TIME_NS * 1000 + `CCD_CLK_PERIOD_PS - 1) / `CCD_CLK_PERIOD_PS
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Special-function register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Nonvolatile configuration bits
  input wire logic i_ext_fast_mode_sel,
  input wire logic i_dual_speed_en,
  input wire logic i_miss_clk_detect_en,
  // Requested clock mode and power state
  input wire logic i_clk_mode_sel,
  input wire logic i_sleep_stop,
  input wire logic i_sleep_stop_alt,
  // Settle clear pulse and flag clear from software
  input wire logic i_settle_count_clear,
  input wire logic i_irq_flag_clear,
  // One pulse per external oscillator cycle
  input wire logic i_ext_osc_edge,
  // Oscillator enables and clock gates
  output ccd_osc_en_type o_osc_en,
  output ccd_gate_type o_gate,
  output logic o_slow_xtal_pin_analog,
  output logic o_sysclk_source_flag,
  output logic o_ext_clk_ready,
  output logic o_miss_clk_irq_flag,
  output logic o_miss_clk_event
);

  //////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Settle and gap counters need at least one cycle, the watchdog two
  if (SETTLE_COUNT < 1 || SETTLE_COUNT > 65535) begin : g_bad_settle
    $error("SETTLE_COUNT out of range");
  end
  if (MISS_CYCLES < 2 || MISS_CYCLES > 65535) begin : g_bad_miss
    $error("MISS_CYCLES out of range");
  end
  if (GAP_CYCLES < 1 || GAP_CYCLES > 255) begin : g_bad_gap
    $error("GAP_CYCLES out of range");
  end

  //////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int SW = $clog2(SETTLE_COUNT + 1);
  localparam int MW = $clog2(MISS_CYCLES + 1);
  localparam logic [SW-1:0] SETTLE_END = SW'(SETTLE_COUNT);
  localparam logic [MW-1:0] MISS_END = MW'(MISS_CYCLES);
  localparam logic [7:0] GAP_END = 8'(GAP_CYCLES);

  logic ext_force_reg; // Bit 7 storage
  logic int_force_reg; // Bit 6 storage
  logic slow_ana_reg; // Bit 4 storage
  logic slow_en_reg; // Bit 3 storage
  logic miss_state_reg; // Parked on internal after a loss
  logic [SW-1:0] settle_reg; // Crystal settle counter
  logic [MW-1:0] idle_reg; // Cycles since last oscillator edge
  logic [7:0] gap_reg; // Dead time between gates
  ccd_state_type state_reg; // Switch sequencer
  ccd_state_type state_next;

  logic sfr_hit; // Access aimed at oscillator_config
  logic wr_hit;
  logic ext_osc_on; // External fast oscillator enabled
  logic ext_ready; // External clock may pass onward
  logic ext_lost; // No edge for the timeout window
  logic want_ext; // Software asks for external
  logic miss_evt; // Missing-clock event this cycle
  logic gap_done;

  //////////////////////////////////////////////////////////////////////
  // Combinational decode

  // Shared address match for read and write
  function automatic logic addr_match(input logic [7:0] a);
    return a == `CCD_OSCILLATOR_CONFIG_ADDR;
  endfunction : addr_match

  assign sfr_hit = addr_match(i_sfr_addr);
  assign wr_hit = i_sfr_wr && sfr_hit;

  // Force bit or requested mode keeps the oscillator running
  assign ext_osc_on = ext_force_reg || i_clk_mode_sel;

  // Clock input mode is usable at once; crystal waits the count
  assign ext_ready = ext_osc_on &&
    (i_ext_fast_mode_sel || settle_reg == SETTLE_END);

  assign ext_lost = idle_reg == MISS_END;

  // Detection only armed while actually running on external
  assign miss_evt = (state_reg == CCD_ON_EXT) && i_miss_clk_detect_en &&
    ext_lost;

  // Parked state blocks the way back until software returns
  assign want_ext = i_clk_mode_sel && !miss_state_reg;

  assign gap_done = gap_reg >= GAP_END - 8'h01;

  //////////////////////////////////////////////////////////////////////
  // Register writes

  // Plain read/write bits of oscillator_config
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ext_force_reg <= 1'b0;
      int_force_reg <= 1'b0;
      slow_ana_reg <= 1'b0;
      slow_en_reg <= 1'b0;
    end else if (i_ce && wr_hit) begin
      ext_force_reg <= i_sfr_wdata[`CCD_BIT_EXT_FORCE];
      int_force_reg <= i_sfr_wdata[`CCD_BIT_INT_FORCE];
      slow_ana_reg <= i_sfr_wdata[`CCD_BIT_SLOW_ANA];
      slow_en_reg <= i_sfr_wdata[`CCD_BIT_SLOW_EN];
    end
  end

  // Read data captured on a read; unmapped or idle reads give zero
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_sfr_rdata <= `CCD_OSCILLATOR_CONFIG_RESET;
    end else if (i_ce) begin
      if (i_sfr_rd && sfr_hit) begin
        // Bit 5 shows the sequencer state being on external, not the request or the gate
        o_sfr_rdata <= {ext_force_reg, int_force_reg,
          state_reg == CCD_ON_EXT, slow_ana_reg, slow_en_reg,
          3'b000};
      end else begin
        o_sfr_rdata <= 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Missing-clock state

  // Loss parks the block on internal; a one on bit 5 releases it.
  // A loss in the same cycle as the release wins, so none is lost.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      miss_state_reg <= 1'b0;
    end else if (i_ce) begin
      if (miss_evt) begin
        miss_state_reg <= 1'b1;
      end else if (wr_hit && i_sfr_wdata[`CCD_BIT_SRC_RET]) begin
        miss_state_reg <= 1'b0;
      end
    end
  end

  // Sticky event flag; hardware set beats software clear
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_miss_clk_irq_flag <= 1'b0;
    end else if (i_ce) begin
      if (miss_evt) begin
        o_miss_clk_irq_flag <= 1'b1;
      end else if (i_irq_flag_clear) begin
        o_miss_clk_irq_flag <= 1'b0;
      end
    end
  end

  // One-cycle interrupt request per event
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_miss_clk_event <= 1'b0;
    end else if (i_ce) begin
      o_miss_clk_event <= miss_evt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Settle counter

  // Counts oscillator edges up to the end value, then holds.
  // Software is expected to pulse clear before a return, else a
  // stale full count would let an unsettled crystal through.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      settle_reg <= '0;
    end else if (i_ce) begin
      if (!ext_osc_on) begin
        settle_reg <= '0;
      end else if (i_settle_count_clear) begin
        settle_reg <= '0;
      end else if (i_ext_fast_mode_sel) begin
        settle_reg <= '0;
      end else if (i_ext_osc_edge && settle_reg != SETTLE_END) begin
        settle_reg <= settle_reg + SW'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Edge watchdog

  // Counts control cycles since the last oscillator edge; saturates.
  // The timeout must exceed one oscillator period or it false-trips.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      idle_reg <= '0;
    end else if (i_ce) begin
      if (!ext_osc_on || i_ext_osc_edge) begin
        idle_reg <= '0;
      end else if (idle_reg != MISS_END) begin
        idle_reg <= idle_reg + MW'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Switch sequencer

  // Next state: both gates are off for the gap between sources
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CCD_ON_INT: begin
        // Dual speed holds on internal until the clock is stable
        if (want_ext && ext_osc_on && (ext_ready || !i_dual_speed_en)) begin
          state_next = CCD_GAP_TO_EXT;
        end
      end
      CCD_GAP_TO_EXT: begin
        if (gap_done) begin
          state_next = CCD_ON_EXT;
        end
      end
      CCD_ON_EXT: begin
        if (miss_evt || !want_ext || !ext_osc_on) begin
          state_next = CCD_GAP_TO_INT;
        end
      end
      CCD_GAP_TO_INT: begin
        if (gap_done) begin
          state_next = CCD_ON_INT;
        end
      end
    endcase
  end

  // State and dead-time counter
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg <= CCD_ON_INT;
      gap_reg <= 8'h00;
    end else if (i_ce) begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        gap_reg <= 8'h00;
      end else if (!gap_done) begin
        gap_reg <= gap_reg + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs

  // Gates: never both open; slow sources have no gate at all
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_gate <= '0;
    end else if (i_ce) begin
      o_gate.int_gate <= state_next == CCD_ON_INT;
      o_gate.ext_gate <= state_next == CCD_ON_EXT &&
        ext_ready;
    end
  end

  // Oscillator enables
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_osc_en <= '0;
      o_slow_xtal_pin_analog <= 1'b0;
    end else if (i_ce) begin
      o_osc_en.ext_fast <= ext_osc_on;
      // Internal runs while in use or forced, never in sleep
      o_osc_en.int_fast <= !i_sleep_stop &&
        (int_force_reg || state_next != CCD_ON_EXT);
      o_osc_en.int_slow <= !i_sleep_stop_alt;
      o_osc_en.slow_xtal <= slow_en_reg && slow_ana_reg;
      o_slow_xtal_pin_analog <= slow_ana_reg;
    end
  end

  // Status mirrors
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_sysclk_source_flag <= 1'b0;
      o_ext_clk_ready <= 1'b0;
    end else if (i_ce) begin
      o_sysclk_source_flag <= state_next == CCD_ON_EXT;
      o_ext_clk_ready <= ext_ready;
    end
  end

endmodule : ccd_clock_ctrl
`default_nettype wire

// >>> logic/ccd_defs.svh
/*
  Offsets, field positions, reset values and timing counts for the
  clock select and missing-clock detect block.
  Assumes a 200 MHz control clock; pure definitions, no logic.
*/
`ifndef CCD_DEFS_SVH
`define CCD_DEFS_SVH

// Special-function register address
`define CCD_OSCILLATOR_CONFIG_ADDR 8'hf1
`define CCD_OSCILLATOR_CONFIG_RESET 8'h00

// Field positions in oscillator_config
`define CCD_BIT_EXT_FORCE 7
`define CCD_BIT_INT_FORCE 6
`define CCD_BIT_SRC_RET 5
`define CCD_BIT_SLOW_ANA 4
`define CCD_BIT_SLOW_EN 3

// Crystal settle length in oscillator cycles
`define CCD_SETTLE_CYCLES 1024

// Control clock period and timing figures
`define CCD_CLK_PERIOD_PS 5000
`define CCD_MISS_TIME_NS 500
`define CCD_GAP_TIME_NS 10

`endif

// >>> logic/ccd_pkg.sv
/*
  Types shared by the clock select block and its bench.
  Assumes ccd_defs.svh holds all numeric constants.
*/
`default_nettype none
package ccd_pkg;

  // Clock switch sequencer states
  typedef enum logic [1:0] {
    CCD_ON_INT,
    CCD_GAP_TO_EXT,
    CCD_ON_EXT,
    CCD_GAP_TO_INT
  } ccd_state_type;

  // Oscillator enable group driven to the analog macros
  typedef struct packed {
    logic ext_fast;
    logic int_fast;
    logic int_slow;
    logic slow_xtal;
  } ccd_osc_en_type;

  // System clock gate group for the glitch-free mux
  typedef struct packed {
    logic int_gate;
    logic ext_gate;
  } ccd_gate_type;

endpackage : ccd_pkg
`default_nettype wire

// >>> bench/ccd_osc_model.sv
/*
  Fast external oscillator model: one pulse per oscillator cycle.
  Assumes its enable comes from the block and i_clk is the control clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ccd_osc_model (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic i_run,
  input wire logic [3:0] i_period,
  output logic o_edge
);
  logic [3:0] cnt_reg; // Cycles since last pulse
  // A disabled or stopped crystal gives no pulses at all
  always_ff @(posedge i_clk) begin
    if (!i_en || !i_run) begin
      cnt_reg <= 4'h0;
      o_edge <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg >= i_period) ? 4'h0 : cnt_reg + 4'h1;
      o_edge <= (cnt_reg == 4'h0);
    end
  end
endmodule : ccd_osc_model
`default_nettype wire

// >>> bench/ccd_clock_ctrl_properties.sv
/*
  Port checks of the clock select block.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defs.svh"
module ccd_clock_ctrl_properties
  import ccd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_ext_fast_mode_sel,
  input wire logic i_sleep_stop,
  input wire logic i_sleep_stop_alt,
  input wire logic i_settle_count_clear,
  input wire ccd_osc_en_type o_osc_en,
  input wire ccd_gate_type o_gate,
  input wire logic o_slow_xtal_pin_analog,
  input wire logic o_sysclk_source_flag,
  input wire logic o_ext_clk_ready,
  input wire logic o_miss_clk_irq_flag,
  input wire logic o_miss_clk_event
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic wr_hit; // Accepted write
  logic rd_hit; // Accepted read
  assign wr_hit = i_ce && i_sfr_wr && (i_sfr_addr == `CCD_OSCILLATOR_CONFIG_ADDR);
  assign rd_hit = i_ce && i_sfr_rd && (i_sfr_addr == `CCD_OSCILLATOR_CONFIG_ADDR);
  ////////////////////////////////////////////////////////////////////
  // Loss event, then fallback to the internal gate
  sequence loss_s;
    o_miss_clk_event && o_miss_clk_irq_flag && !o_gate.ext_gate;
  endsequence
  sequence fallback_s;
    ##2 o_gate.int_gate;
  endsequence
  gates_apart_a: assert property (!(o_gate.int_gate && o_gate.ext_gate))
    else $error("both clock gates open");
  // Register bit lands one edge after the write, the enable one edge later
  ext_force_a: assert property (wr_hit && i_sfr_wdata[7] |-> ##2 o_osc_en.ext_fast)
    else $error("forced external oscillator off");
  int_sleep_a: assert property (i_ce && i_sleep_stop |=> !o_osc_en.int_fast)
    else $error("fast internal runs in sleep");
  slow_sleep_a: assert property (i_ce && i_sleep_stop_alt |=> !o_osc_en.int_slow)
    else $error("slow internal runs in sleep");
  // Slow crystal runs only with its pins analog as well
  slow_bits_a: assert property (
    wr_hit |-> ##2 o_slow_xtal_pin_analog == $past(i_sfr_wdata[4], 2) &&
      o_osc_en.slow_xtal == ($past(i_sfr_wdata[4], 2) && $past(i_sfr_wdata[3], 2)))
    else $error("slow crystal bits wrong");
  ready_gate_a: assert property (o_gate.ext_gate |-> o_ext_clk_ready)
    else $error("external gate open before ready");
  osc_off_a: assert property ((!o_osc_en.ext_fast) [*2] |-> !o_ext_clk_ready)
    else $error("ready while oscillator off");
  clear_drop_a: assert property (
    i_ce && i_settle_count_clear && !i_ext_fast_mode_sel |-> ##2 !o_ext_clk_ready)
    else $error("clear did not drop ready");
  loss_fallback_a: assert property (loss_s |-> fallback_s)
    else $error("no fallback after loss");
  clk_input_a: assert property (
    i_ext_fast_mode_sel && $rose(o_osc_en.ext_fast) |-> ##[0:2] o_ext_clk_ready)
    else $error("clock input mode not ready");
  read_src_a: assert property (
    rd_hit |=> o_sfr_rdata[2:0] == 3'h0 && o_sfr_rdata[5] == $past(o_sysclk_source_flag))
    else $error("read data source bit wrong");
endmodule : ccd_clock_ctrl_properties
bind ccd_clock_ctrl ccd_clock_ctrl_properties u_props (.*);
`default_nettype wire

// >>> bench/tb.sv
/*
  Bench of the clock select block: register, settle, switch, loss, sleep.
  Assumes the oscillator model stands in for the external crystal.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defs.svh"
module tb
  import ccd_pkg::*;
();
  localparam int SETTLE = 8; // Shortened settle count
  localparam logic [7:0] CFG = `CCD_OSCILLATOR_CONFIG_ADDR;
  logic clk, rstn, ce, wr, rd, mode, dual, mcd, mode_req, slp, slpa, clr, fclr, run, osc_pulse;
  logic pin_ana, src, rdy, flag, evt;
  logic [3:0] per;
  logic [7:0] addr, wdata, rdata;
  ccd_osc_en_type osc_en;
  ccd_gate_type gate;
  int error_cnt, samples_checked, pulses;
  ccd_clock_ctrl #(.SETTLE_COUNT(SETTLE), .MISS_CYCLES(8)) u_dut (
    .i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_ext_fast_mode_sel(mode),
    .i_dual_speed_en(dual), .i_miss_clk_detect_en(mcd), .i_clk_mode_sel(mode_req),
    .i_sleep_stop(slp), .i_sleep_stop_alt(slpa), .i_settle_count_clear(clr),
    .i_irq_flag_clear(fclr), .i_ext_osc_edge(osc_pulse), .o_osc_en(osc_en), .o_gate(gate),
    .o_slow_xtal_pin_analog(pin_ana), .o_sysclk_source_flag(src), .o_ext_clk_ready(rdy),
    .o_miss_clk_irq_flag(flag), .o_miss_clk_event(evt));
  ccd_osc_model u_osc (.i_clk(clk), .i_en(osc_en.ext_fast), .i_run(run), .i_period(per),
    .o_edge(osc_pulse));
  ////////////////////////////////////////////////////////////////////
  // Clock, pulse counter and tasks
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Pulses seen while the settle wait lasts
  always @(posedge clk) if (osc_en.ext_fast && !rdy && osc_pulse) pulses++;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic do_reset;
    rstn = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
  endtask : do_reset
  // Strobe held over one rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  // Data stands one cycle after the read edge
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(what, exp, rdata);
  endtask : rd_reg
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // Cut a hang short
  initial begin
    #100000;
    error_cnt++;
    $display("mismatch watchdog expected done seen timeout");
    summarize();
  end
  ////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    pulses = 0;
    {rd, wr, mode, mode_req, slp, slpa, clr, fclr} = 8'h00;
    {ce, dual, mcd, run} = 4'hf;
    per = 4'h4;
    addr = 8'h00;
    wdata = 8'h00;
    do_reset();
    rd_reg(CFG, 8'h00, "reset value");
    wr_reg(8'hf0, 8'hff);
    rd_reg(8'hf0, 8'h00, "unmapped read");
    rd_reg(CFG, 8'h00, "after unmapped write");
    $display("test registers done");
    wr_reg(CFG, 8'hd8);
    // Enables follow the stored bits one edge later
    @(negedge clk);
    chk("ext osc on", 8'h01, 8'(osc_en.ext_fast));
    chk("int osc on", 8'h01, 8'(osc_en.int_fast));
    chk("slow pins", 8'h01, 8'(pin_ana));
    chk("slow xtal", 8'h01, 8'(osc_en.slow_xtal));
    rd_reg(CFG, 8'hd8, "config readback");
    for (int n = 0; n < 200 && !rdy; n++) @(negedge clk);
    chk("settle pulses", 8'(SETTLE), 8'(pulses));
    run = 1'b0;
    clr = 1'b1;
    repeat (3) @(negedge clk);
    chk("ready after clear", 8'h00, 8'(rdy));
    {clr, run, pulses} = {2'h1, 32'h0000_0000};
    for (int n = 0; n < 200 && !rdy; n++) @(negedge clk);
    chk("pulses after clear", 8'(SETTLE), 8'(pulses));
    $display("test settle done");
    mode_req = 1'b1;
    for (int n = 0; n < 50 && !gate.ext_gate; n++) @(negedge clk);
    rd_reg(CFG, 8'hf8, "source external");
    run = 1'b0;
    for (int n = 0; n < 50 && !evt; n++) @(negedge clk);
    chk("loss flag", 8'h01, 8'(flag));
    repeat (3) @(negedge clk);
    chk("event pulse", 8'h00, 8'(evt));
    chk("int gate back", 8'h01, 8'(gate.int_gate));
    rd_reg(CFG, 8'hd8, "source after loss");
    run = 1'b1;
    wr_reg(CFG, 8'hd8);
    repeat (20) @(negedge clk);
    chk("parked gate", 8'h00, 8'(gate.ext_gate));
    fclr = 1'b1;
    @(negedge clk);
    fclr = 1'b0;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    chk("flag cleared", 8'h00, 8'(flag));
    wr_reg(CFG, 8'hf8);
    // Crystal still settling: dual speed must keep the internal source
    repeat (5) @(negedge clk);
    chk("dual speed hold", 8'h00, 8'(src));
    for (int n = 0; n < 200 && !gate.ext_gate; n++) @(negedge clk);
    chk("source returned", 8'h01, 8'(src));
    $display("test switch done");
    {slp, slpa} = 2'h3;
    repeat (2) @(negedge clk);
    chk("sleep int fast", 8'h00, 8'(osc_en.int_fast));
    chk("sleep int slow", 8'h00, 8'(osc_en.int_slow));
    {slp, slpa, mode_req, mode} = 4'h1;
    do_reset();
    wr_reg(CFG, 8'h80);
    @(negedge clk);
    chk("clock input ready", 8'h01, 8'(rdy));
    // Clock enable low: the write must be ignored and outputs hold
    ce = 1'b0;
    wr_reg(CFG, 8'h00);
    @(negedge clk);
    chk("frozen ready", 8'h01, 8'(rdy));
    ce = 1'b1;
    repeat (2) @(negedge clk);
    chk("force kept", 8'h01, 8'(osc_en.ext_fast));
    $display("test sleep and input done");
    summarize();
  end
endmodule : tb
`default_nettype wire
